// [refsel_defs.svh]
// register offsets, field positions, reset values and timing counts for the reference selector
`ifndef REFSEL_DEFS_SVH
`define REFSEL_DEFS_SVH

// register indices, byte address is four times the index
`define MODE_IDX 8'h1f
`define CHOICE_IDX 8'h20
`define MASK_IDX 8'h21
`define RESTORE_IDX 8'h22
`define REVERT_IDX 8'h23
`define RANK0_IDX 8'h24
`define STATUS_IDX 8'h30
`define ADDR_W 8

// reset values
`define MODE_RST 8'h03
`define CHOICE_RST 8'h00
`define MASK_RST 8'h3c
`define RESTORE_RST 8'h00
`define REVERT_RST 8'h00
`define RANK0_RST 8'h10

// field positions
`define SW_MASK_LSB 0
`define HOLD_MASK_LSB 4
`define STAT_QUAL_LSB 0
`define STAT_STATE_LSB 12
`define STAT_REF_LSB 16

// selection codes and ranks
`define NUM_INPUTS 9
`define LAST_INPUT 4'h8
`define RANK_OFF 4'hf

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// timing: one minute at the 100 MHz system clock
`define CLK_HZ 100000000
`define MINUTE_SEC 60
`define CYC_PER_MIN (64'd`CLK_HZ * 64'd`MINUTE_SEC)

`endif

// [refsel_pkg.sv]
// types shared by the reference selector files
package refsel_pkg;

  // operating mode of the first digital loop
  typedef enum logic [1:0] {
    MODE_MANUAL_NORMAL,
    MODE_MANUAL_HOLDOVER,
    MODE_MANUAL_FREERUN,
    MODE_AUTO_NORMAL
  } loop_mode_t;

  // reported loop state
  typedef enum logic [1:0] {
    ST_FREERUN,
    ST_HOLDOVER,
    ST_LOCKED
  } loop_state_t;

  // failure indicators of one reference input
  typedef struct packed {
    logic precise_frequency_check;
    logic guard_soak_timer;
    logic coarse_frequency_check;
    logic single_cycle_check;
  } fail_vec_t;

endpackage : refsel_pkg

// [restore_qualifier.sv]
// per-input failure synchroniser, masking and restore_delay_minutes qualification
`timescale 1ns/1ps
`include "refsel_defs.svh"

module restore_qualifier #(
  parameter logic [39:0] CYC_PER_MIN = 40'd6000000000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // raw indicators from the monitors
  input wire refsel_pkg::fail_vec_t fail_raw,
  // settings
  input wire logic [3:0] switch_failure_gate,
  input wire logic [3:0] hold_gate,
  input wire logic [3:0] restore_delay_minutes,
  // results
  output logic sw_fail,
  output logic hold_fail,
  output logic qual
);

  // ======================================================
  // input synchroniser
  logic [3:0] sync1_r, sync2_r, sync3_r, fail_r;

  // three stages, accepted once stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
      fail_r <= 4'h0;
    end else if (ce) begin
      sync1_r <= fail_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) fail_r <= sync3_r;
    end
  end

  // ======================================================
  // masking and restore timer
  logic [39:0] cyc_r, cyc_nxt;
  logic [3:0] min_r, min_nxt;
  wire waiting = (min_r < restore_delay_minutes);

  assign sw_fail = |(fail_r & switch_failure_gate); // RULE_05 RULE_07
  assign hold_fail = |(fail_r & hold_gate); // RULE_06 RULE_07
  assign qual = !sw_fail && !waiting; // RULE_14

  // restart on failure, then count whole minutes fault-free
  always_comb begin
    cyc_nxt = cyc_r;
    min_nxt = min_r;
    if (sw_fail) begin
      cyc_nxt = 40'h0; // RULE_08
      min_nxt = 4'h0;
    end else if (waiting) begin
      if (cyc_r == CYC_PER_MIN - 40'h1) begin
        cyc_nxt = 40'h0;
        min_nxt = min_r + 4'h1; // RULE_08
      end else begin
        cyc_nxt = cyc_r + 40'h1;
      end
    end
  end

  // never-failed inputs start as available
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cyc_r <= 40'h0;
      min_r <= 4'hf;
    end else if (ce) begin
      cyc_r <= cyc_nxt;
      min_r <= min_nxt;
    end
  end

  // ======================================================
  // checks
  a_restore_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
    ($fell(sw_fail) && restore_delay_minutes != 4'h0) |-> !qual) else $error("input qualified before restore time");
  a_fail_unqual: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_14
    (ce && sw_fail) |=> (min_r == 4'h0 || !ce)) else $error("failure did not restart restore timer");

endmodule : restore_qualifier

// [dpll_reference_selector.sv]
// reference selection control and status for the first digital loop, with an AXI4-Lite register slave
//
// Notes on behaviour
// RULE_01 - in automatic normal mode the reference choice register reads back the input the block has chosen.
// RULE_02 - in manual normal mode the value written to the reference choice register picks the loop input.
// RULE_03 - selection codes 0 to 8 name inputs 0 to 8, codes 9 to 15 are reserved and not accepted.
// RULE_04 - the reference choice register is read-only in automatic mode and read-write in manual mode; the code takes writes in manual normal mode only.
// RULE_05 - mask bits 3:0 gate which failure indicators drive automatic switching.
// RULE_06 - mask bits 7:4 gate which failure indicators force holdover.
// RULE_07 - a zero mask bit ignores its indicator and a one lets it act.
// RULE_08 - a failed input stays unavailable until fault-free for the programmed whole minutes, zero meaning none.
// RULE_09 - one revertive enable bit per input 0 to 7 chooses revertive or non-revertive switching.
// RULE_10 - bits 3:0 of the first rank register rank input 0 for automatic selection.
// RULE_11 - rank 0 is highest, larger is lower, and 15 excludes input 0.
// RULE_12 - in manual normal mode a failure of the chosen input puts the loop into holdover.
// RULE_13 - automatic mode picks the best qualified input, moves on failure, and holds over when none is left.
// RULE_14 - an input with an active switching failure or an unexpired restore time is not qualified.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "refsel_defs.svh"

module dpll_reference_selector #(
  parameter logic [39:0] CYC_PER_MIN = 40'(`CYC_PER_MIN)
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // failure indicators of the nine inputs
  input wire refsel_pkg::fail_vec_t [8:0] fail_ind,
  // loop control
  output logic [3:0] active_ref,
  output refsel_pkg::loop_state_t loop_state,
  output logic [8:0] qualified
);

  // ======================================================
  // registers
  logic [1:0] mode_r;
  logic [3:0] manual_sel_r;
  logic [7:0] mask_r, restore_r, revert_r, rank0_r;
  logic [3:0] active_ref_r, active_ref_nxt;
  refsel_pkg::loop_state_t state_r, state_nxt;
  logic [8:0] qual_r;

  wire mode_auto = (mode_r == refsel_pkg::MODE_AUTO_NORMAL);
  wire mode_manual = (mode_r == refsel_pkg::MODE_MANUAL_NORMAL);

  // ======================================================
  // per-input qualification
  logic [8:0] sw_fail_vec, hold_fail_vec, qual_vec;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_INPUTS; gi++) begin : g_in
      restore_qualifier #(.CYC_PER_MIN(CYC_PER_MIN)) u_qual (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .fail_raw(fail_ind[gi]),
        .switch_failure_gate(mask_r[`SW_MASK_LSB +: 4]),
        .hold_gate(mask_r[`HOLD_MASK_LSB +: 4]),
        .restore_delay_minutes(restore_r[3:0]),
        .sw_fail(sw_fail_vec[gi]),
        .hold_fail(hold_fail_vec[gi]),
        .qual(qual_vec[gi])
      );
    end
  endgenerate

  // ======================================================
  // rank of each input and best qualified candidate
  logic [3:0] rank [0:8];
  logic [3:0] best_idx, best_rank;
  logic best_valid;

  // input 0 ranked by register, the others by their number
  always_comb begin
    rank[0] = rank0_r[3:0]; // RULE_10
    for (int n = 1; n < `NUM_INPUTS; n++) begin
      rank[n] = 4'(n);
    end
  end

  // lowest rank wins, ties go to the lower input number
  always_comb begin
    best_idx = 4'h0;
    best_rank = `RANK_OFF;
    best_valid = 1'b0;
    for (int n = 0; n < `NUM_INPUTS; n++) begin
      if (qual_vec[n] && rank[n] != `RANK_OFF && (!best_valid || rank[n] < best_rank)) begin // RULE_11 RULE_14
        best_idx = 4'(n);
        best_rank = rank[n];
        best_valid = 1'b1;
      end
    end
  end

  // ======================================================
  // selection decisions
  wire cur_in_range = (active_ref_r <= `LAST_INPUT);
  wire [3:0] cur_rank = cur_in_range ? rank[active_ref_r] : `RANK_OFF;
  wire cur_ok = cur_in_range && qual_vec[active_ref_r] && cur_rank != `RANK_OFF && state_r == refsel_pkg::ST_LOCKED;
  wire best_revert = (best_idx < `LAST_INPUT) && revert_r[best_idx[2:0]]; // RULE_09
  wire auto_switch = best_valid && (!cur_ok || (best_revert && best_rank < cur_rank)); // RULE_09 RULE_13
  wire [3:0] auto_ref = auto_switch ? best_idx : active_ref_r;
  wire auto_hold = (!cur_ok && !best_valid) || hold_fail_vec[auto_ref]; // RULE_06 RULE_13
  wire manual_hold = hold_fail_vec[manual_sel_r]; // RULE_12

  // next selection and loop state per mode
  always_comb begin
    active_ref_nxt = active_ref_r;
    state_nxt = state_r;
    case (mode_r)
      refsel_pkg::MODE_MANUAL_NORMAL: begin
        active_ref_nxt = manual_sel_r; // RULE_02
        state_nxt = manual_hold ? refsel_pkg::ST_HOLDOVER : refsel_pkg::ST_LOCKED; // RULE_12
      end
      refsel_pkg::MODE_MANUAL_HOLDOVER: state_nxt = refsel_pkg::ST_HOLDOVER;
      refsel_pkg::MODE_MANUAL_FREERUN: state_nxt = refsel_pkg::ST_FREERUN;
      refsel_pkg::MODE_AUTO_NORMAL: begin
        active_ref_nxt = auto_ref; // RULE_13
        state_nxt = auto_hold ? refsel_pkg::ST_HOLDOVER : refsel_pkg::ST_LOCKED; // RULE_13
      end
      default: state_nxt = refsel_pkg::ST_FREERUN;
    endcase
  end

  // loop state flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      active_ref_r <= 4'h0;
      state_r <= refsel_pkg::ST_FREERUN;
      qual_r <= 9'h000;
    end else if (ce) begin
      active_ref_r <= active_ref_nxt;
      state_r <= state_nxt;
      qual_r <= qual_vec;
    end
  end

  assign active_ref = active_ref_r;
  assign loop_state = state_r;
  assign qualified = qual_r;

  // ======================================================
  // axi4-lite write path
  logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r;
  logic [1:0] bresp_r;
  logic [`ADDR_W-1:0] waddr_r;
  logic [7:0] wbyte_r;
  logic wlane_r;

  wire aw_fire = s_axi_awvalid && awready_r;
  wire w_fire = s_axi_wvalid && wready_r;
  wire wr_go = aw_held_r && w_held_r && !bvalid_r;
  wire [5:0] widx = waddr_r[7:2];
  wire wr_mode = (widx == 6'(`MODE_IDX));
  wire wr_choice = (widx == 6'(`CHOICE_IDX));
  wire wr_mask = (widx == 6'(`MASK_IDX));
  wire wr_restore = (widx == 6'(`RESTORE_IDX));
  wire wr_revert = (widx == 6'(`REVERT_IDX));
  wire wr_rank0 = (widx == 6'(`RANK0_IDX));
  wire wr_status = (widx == 6'(`STATUS_IDX));
  wire wr_hit = wr_mode | wr_choice | wr_mask | wr_restore | wr_revert | wr_rank0 | wr_status;
  wire wr_en = wr_go && wlane_r;
  wire choice_ok = mode_manual && wbyte_r[3:0] <= `LAST_INPUT; // RULE_03 RULE_04

  // capture address and data in either order, answer once both are held
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      waddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (ce) begin
      if (aw_fire) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        waddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // software settings, status register is read-only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= 2'(`MODE_RST);
      manual_sel_r <= 4'(`CHOICE_RST);
      mask_r <= `MASK_RST;
      restore_r <= `RESTORE_RST;
      revert_r <= `REVERT_RST;
      rank0_r <= `RANK0_RST;
    end else if (ce && wr_en) begin
      if (wr_mode) mode_r <= wbyte_r[1:0];
      if (wr_choice && choice_ok) manual_sel_r <= wbyte_r[3:0]; // RULE_02 RULE_04
      if (wr_mask) mask_r <= wbyte_r; // RULE_05 RULE_06
      if (wr_restore) restore_r <= {4'h0, wbyte_r[3:0]}; // RULE_08
      if (wr_revert) revert_r <= wbyte_r; // RULE_09
      if (wr_rank0) rank0_r <= wbyte_r; // RULE_10
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ======================================================
  // axi4-lite read path
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire ar_fire = s_axi_arvalid && arready_r;
  wire [5:0] ridx = s_axi_araddr[7:2];
  wire [3:0] choice_view = mode_auto ? active_ref_r : manual_sel_r; // RULE_01
  wire [31:0] status_view = {12'h000, active_ref_r, 2'b00, 2'(state_r), 3'b000, qual_r};
  logic [31:0] rd_mux;
  logic rd_hit;

  // register read selection
  always_comb begin
    rd_hit = 1'b1;
    case (ridx)
      6'(`MODE_IDX): rd_mux = {30'h0, mode_r};
      6'(`CHOICE_IDX): rd_mux = {28'h0, choice_view}; // RULE_01 RULE_04
      6'(`MASK_IDX): rd_mux = {24'h0, mask_r};
      6'(`RESTORE_IDX): rd_mux = {24'h0, restore_r};
      6'(`REVERT_IDX): rd_mux = {24'h0, revert_r};
      6'(`RANK0_IDX): rd_mux = {24'h0, rank0_r};
      6'(`STATUS_IDX): rd_mux = status_view;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read in flight, data held until taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ======================================================
  // checks
  a_auto_report: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_01
    (ce && ar_fire && mode_auto && ridx == 6'(`CHOICE_IDX)) |=> s_axi_rdata[3:0] == $past(active_ref_r))
    else $error("auto choice not reported");
  a_manual_follow: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_02
    (ce && mode_manual) |=> active_ref_r == $past(manual_sel_r)) else $error("manual choice not followed");
  a_code_range: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
    (ce && wr_en && wr_choice && wbyte_r[3:0] > `LAST_INPUT) |=> manual_sel_r == $past(manual_sel_r))
    else $error("reserved code accepted");
  a_auto_readonly: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_04
    (ce && wr_en && wr_choice && mode_auto) |=> $stable(manual_sel_r)) else $error("choice written in auto mode");
  a_switch_mask: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_05 RULE_07 RULE_14
    (ce && mode_auto && cur_in_range && sw_fail_vec[active_ref_r] && best_valid) |=> active_ref_r == $past(best_idx))
    else $error("failing input kept in use");
  a_manual_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06 RULE_12
    (ce && mode_manual && hold_fail_vec[manual_sel_r]) |=> state_r == refsel_pkg::ST_HOLDOVER)
    else $error("manual failure without holdover");
  a_auto_empty: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_13
    (ce && mode_auto && !best_valid && !cur_ok) |=> state_r == refsel_pkg::ST_HOLDOVER)
    else $error("no input yet not holding over");
  a_auto_pick: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_11 RULE_13
    (ce && mode_auto && best_valid && !cur_ok) |=> active_ref_r == $past(best_idx))
    else $error("best input not picked");
  a_excluded_rank: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_10 RULE_11
    (best_valid && best_idx == 4'h0) |-> rank0_r[3:0] != `RANK_OFF) else $error("excluded input zero chosen");
  a_nonrevert: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_09
    (ce && mode_auto && cur_ok && revert_r == 8'h00) |=> $stable(active_ref_r))
    else $error("switched without revertive enable");

  c_auto_switch: cover property (@(posedge clk_sys) disable iff (!arst_n) ce && mode_auto && auto_switch && cur_ok);
  c_auto_hold: cover property (@(posedge clk_sys) disable iff (!arst_n) mode_auto && state_r == refsel_pkg::ST_HOLDOVER);
  c_manual_write: cover property (@(posedge clk_sys) disable iff (!arst_n) wr_en && wr_choice && choice_ok);

endmodule : dpll_reference_selector

// [dpll_reference_selector_test.sv]
// self-checking testbench for the reference selector through its axi4-lite register port
`timescale 1ns/1ps
`include "refsel_defs.svh"

module dpll_reference_selector_test;
  // ====================
  // design hookup
  logic clk_sys;
  logic arst_n;
  logic ce;
  logic [`ADDR_W-1:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [`ADDR_W-1:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  refsel_pkg::fail_vec_t [8:0] fail_ind;
  logic [3:0] active_ref;
  refsel_pkg::loop_state_t loop_state;
  logic [8:0] qualified;
  int n_fail = 0;
  int checks = 0;
  // register indices and their reset values
  logic [7:0] reg_idx [6] = '{`MODE_IDX, `CHOICE_IDX, `MASK_IDX, `RESTORE_IDX, `REVERT_IDX, `RANK0_IDX};
  logic [7:0] reg_rst [6] = '{`MODE_RST, `CHOICE_RST, `MASK_RST, `RESTORE_RST, `REVERT_RST, `RANK0_RST};

  // one minute shortened to 20 cycles
  dpll_reference_selector #(.CYC_PER_MIN(40'd20)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fail_ind(fail_ind),
    .active_ref(active_ref), .loop_state(loop_state), .qualified(qualified)
  );

  // ====================
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ====================
  // report and compare tasks
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_resp

  task automatic timed_out(input string what);
    n_fail++;
    $display("mismatch %s expected answer seen timeout", what);
    complete_run();
  endtask : timed_out

  function automatic logic [7:0] byte_of(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : byte_of

  // ====================
  // axi4-lite master tasks
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] exp_resp);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= byte_of(idx);
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, data};
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (s_axi_bvalid !== 1'b1) timed_out("bvalid");
    cmp_resp("bresp", exp_resp, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] exp_resp);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= byte_of(idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (s_axi_rvalid !== 1'b1) timed_out("rvalid");
    cmp_word("rdata", exp, s_axi_rdata);
    cmp_resp("rresp", exp_resp, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask : rd_chk

  // let things settle, then wait for the loop to reach the expected input and state
  task automatic wait_loop(input logic [3:0] r, input refsel_pkg::loop_state_t s, input bit any_ref);
    int n;
    n = 0;
    repeat (4) @(negedge clk_sys);
    while (n < 20 && !(loop_state === s && (any_ref || active_ref === r))) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_word("loop_state", {30'h0, s}, {30'h0, loop_state});
    if (!any_ref) cmp_word("active_ref", {28'h0, r}, {28'h0, active_ref});
    if (!(loop_state === s && (any_ref || active_ref === r))) complete_run();
  endtask : wait_loop

  task automatic wait_qual(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (n < lim && qualified[i] !== v) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_word("qualified", {31'h0, v}, {31'h0, qualified[i]});
    if (qualified[i] !== v) complete_run();
  endtask : wait_qual

  // ====================
  // main sequence
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    fail_ind = '0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    // register reset values, access kinds and an unmapped place
    for (int i = 0; i < 6; i++) rd_chk(reg_idx[i], {24'h0, reg_rst[i]}, `RESP_OKAY);
    rd_chk(8'h3f, 32'h00000000, `RESP_SLVERR);
    axi_write(8'h3f, 8'h55, `RESP_SLVERR);
    axi_write(`REVERT_IDX, 8'ha5, `RESP_OKAY);
    rd_chk(`REVERT_IDX, 32'h000000a5, `RESP_OKAY);
    axi_write(`REVERT_IDX, 8'h00, `RESP_OKAY);
    axi_write(`RESTORE_IDX, 8'hff, `RESP_OKAY);
    rd_chk(`RESTORE_IDX, 32'h0000000f, `RESP_OKAY);
    $display("test registers done");
    // automatic mode: choice reports the pick and refuses writes
    wait_loop(4'h0, refsel_pkg::ST_LOCKED, 1'b0);
    axi_write(`CHOICE_IDX, 8'h05, `RESP_OKAY);
    rd_chk(`CHOICE_IDX, 32'h00000000, `RESP_OKAY);
    // rank and revertive enables
    axi_write(`RANK0_IDX, 8'h12, `RESP_OKAY);
    wait_loop(4'h0, refsel_pkg::ST_LOCKED, 1'b0);
    axi_write(`REVERT_IDX, 8'h03, `RESP_OKAY);
    wait_loop(4'h1, refsel_pkg::ST_LOCKED, 1'b0);
    rd_chk(`CHOICE_IDX, 32'h00000001, `RESP_OKAY);
    axi_write(`RANK0_IDX, 8'h10, `RESP_OKAY);
    wait_loop(4'h0, refsel_pkg::ST_LOCKED, 1'b0);
    $display("test auto rank done");
    // masks: single-cycle only forces holdover, guard-soak only switches
    @(posedge clk_sys);
    fail_ind[0] <= 4'h1;
    wait_loop(4'h0, refsel_pkg::ST_HOLDOVER, 1'b0);
    wait_qual(0, 1'b1, 1);
    @(posedge clk_sys);
    fail_ind[0] <= 4'h0;
    wait_loop(4'h0, refsel_pkg::ST_LOCKED, 1'b0);
    axi_write(`RESTORE_IDX, 8'h02, `RESP_OKAY);
    axi_write(`REVERT_IDX, 8'h00, `RESP_OKAY);
    @(posedge clk_sys);
    fail_ind[0] <= 4'h4;
    wait_loop(4'h1, refsel_pkg::ST_LOCKED, 1'b0);
    wait_qual(0, 1'b0, 1);
    @(posedge clk_sys);
    fail_ind[0] <= 4'h0;
    // two minutes of 20 cycles must pass fault-free
    repeat (30) @(negedge clk_sys);
    cmp_word("qualified", 32'h0, {31'h0, qualified[0]});
    wait_qual(0, 1'b1, 40);
    wait_loop(4'h1, refsel_pkg::ST_LOCKED, 1'b0);
    axi_write(`REVERT_IDX, 8'h01, `RESP_OKAY);
    wait_loop(4'h0, refsel_pkg::ST_LOCKED, 1'b0);
    $display("test masks and restore done");
    // excluded rank with zero restore time
    axi_write(`RESTORE_IDX, 8'h00, `RESP_OKAY);
    axi_write(`RANK0_IDX, 8'h1f, `RESP_OKAY);
    wait_loop(4'h1, refsel_pkg::ST_LOCKED, 1'b0);
    @(posedge clk_sys);
    fail_ind[0] <= 4'h4;
    wait_loop(4'h1, refsel_pkg::ST_LOCKED, 1'b0);
    wait_qual(0, 1'b0, 10);
    @(posedge clk_sys);
    fail_ind[0] <= 4'h0;
    wait_qual(0, 1'b1, 10);
    wait_loop(4'h1, refsel_pkg::ST_LOCKED, 1'b0);
    // no qualified input left
    @(posedge clk_sys);
    fail_ind <= {9{4'h8}};
    wait_loop(4'h0, refsel_pkg::ST_HOLDOVER, 1'b1);
    @(posedge clk_sys);
    fail_ind <= '0;
    wait_loop(4'h1, refsel_pkg::ST_LOCKED, 1'b0);
    $display("test exclusion and holdover done");
    // manual normal mode: every code, a reserved code, failure of the choice
    axi_write(`MODE_IDX, 8'h00, `RESP_OKAY);
    for (int k = 0; k < 9; k++) begin
      axi_write(`CHOICE_IDX, 8'(k), `RESP_OKAY);
      wait_loop(4'(k), refsel_pkg::ST_LOCKED, 1'b0);
      rd_chk(`CHOICE_IDX, 32'(k), `RESP_OKAY);
    end
    axi_write(`CHOICE_IDX, 8'h09, `RESP_OKAY);
    rd_chk(`CHOICE_IDX, 32'h00000008, `RESP_OKAY);
    wait_loop(4'h8, refsel_pkg::ST_LOCKED, 1'b0);
    axi_write(`CHOICE_IDX, 8'h03, `RESP_OKAY);
    @(posedge clk_sys);
    fail_ind[3] <= 4'h2;
    wait_loop(4'h3, refsel_pkg::ST_HOLDOVER, 1'b0);
    axi_write(`MASK_IDX, 8'h0c, `RESP_OKAY);
    wait_loop(4'h3, refsel_pkg::ST_LOCKED, 1'b0);
    // enable low freezes qualification, then the forced manual modes
    @(posedge clk_sys);
    ce <= 1'b0;
    fail_ind[3] <= 4'h6;
    repeat (10) @(negedge clk_sys);
    cmp_word("qualified", 32'h1, {31'h0, qualified[3]});
    @(posedge clk_sys);
    ce <= 1'b1;
    wait_qual(3, 1'b0, 10);
    axi_write(`MODE_IDX, 8'h01, `RESP_OKAY);
    wait_loop(4'h3, refsel_pkg::ST_HOLDOVER, 1'b0);
    axi_write(`MODE_IDX, 8'h02, `RESP_OKAY);
    wait_loop(4'h3, refsel_pkg::ST_FREERUN, 1'b0);
    $display("test manual done");
    complete_run();
  end
endmodule : dpll_reference_selector_test
